// file: autoneg_next_page_transmit_reg.sv
`timescale 1ns/10ps
`default_nettype none
`include "np_tx_regs.svh"
module autoneg_next_page_transmit_reg
  import np_tx_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic ARB_STATUS_LOAD,
  input wire logic ARB_PAGE_TYPE,
  input wire logic ARB_COMPLY,
  input wire logic LCW_SENT,
  input wire logic LCW_SENT_TOGGLE,
  output logic [15:0] NEXT_PAGE_WORD,
  output logic MORE_PAGES
);

  localparam logic [ADDR_W-1:0] REG_ADDR =
    ADDR_W'(`NPT_REG_IDX) << `NPT_WORD_SHIFT;

  logic more_pages_q;
  logic page_type_q;
  logic comply_ack_q;
  logic sent_toggle_q;
  page_code_t code_q;
  page_word_t page_word;
  logic setup;
  logic access;
  logic hit;
  logic wr_hit;
  bus_word_t rdata_q;
  logic err_q;

  // whole-word match only; the low two address bits must be zero
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == REG_ADDR);
  endfunction

  function automatic logic lane_on(input logic [3:0] strb, input int lane);
    lane_on = strb[lane];
  endfunction

  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign hit = addr_hit(PADDR);
  assign wr_hit = access && PWRITE && hit;

  // reserved bit 14 is never stored, so it always reads back as zero
  always_comb begin
    page_word = '0;
    page_word[`NPT_MORE_BIT] = more_pages_q;
    page_word[`NPT_TYPE_BIT] = page_type_q;
    page_word[`NPT_ACK_BIT] = comply_ack_q;
    page_word[`NPT_TOG_BIT] = sent_toggle_q;
    page_word[`NPT_CODE_MSB:`NPT_CODE_LSB] = code_q;
  end

  // more-pages flag: software owned
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      more_pages_q <= `NPT_MORE_RST;
    end else if (wr_hit && lane_on(PSTRB, `NPT_HI_LANE)) begin
      more_pages_q <= PWDATA[`NPT_MORE_BIT];
    end
  end

  // code field straddles both low byte lanes, each lane honoured alone
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      code_q <= `NPT_CODE_RST;
    end else if (wr_hit) begin
      if (lane_on(PSTRB, `NPT_LO_LANE)) begin
        code_q[`NPT_LO_LANE_MSB:`NPT_CODE_LSB] <= PWDATA[`NPT_LO_LANE_MSB:`NPT_CODE_LSB];
      end
      if (lane_on(PSTRB, `NPT_HI_LANE)) begin
        code_q[`NPT_CODE_MSB:`NPT_HI_LANE_LSB] <= PWDATA[`NPT_CODE_MSB:`NPT_HI_LANE_LSB];
      end
    end
  end

  // page type and comply ack belong to the arbitration logic, not software
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      page_type_q <= `NPT_TYPE_RST;
      comply_ack_q <= `NPT_ACK_RST;
    end else if (ARB_STATUS_LOAD) begin
      page_type_q <= ARB_PAGE_TYPE;
      comply_ack_q <= ARB_COMPLY;
    end
  end

  np_toggle_track u_toggle (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .word_sent(LCW_SENT),
    .sent_toggle(LCW_SENT_TOGGLE),
    .toggle_q(sent_toggle_q)
  );

  // read data and error are captured in setup so both stand in the access cycle
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rdata_q <= `NPT_RDATA_IDLE;
    end else if (setup) begin
      rdata_q <= (!PWRITE && hit) ? {16'h0000, page_word} : `NPT_RDATA_IDLE;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      err_q <= 1'b0;
    end else if (setup) begin
      err_q <= !hit;
    end
  end

  // zero wait states; a write to the read-only fields is silently dropped
  assign PREADY = 1'b1;
  assign PRDATA = rdata_q;
  assign PSLVERR = access && err_q;

  // the arbitration side takes the page straight from the register
  assign NEXT_PAGE_WORD = page_word;
  assign MORE_PAGES = more_pages_q;

  // helper: marks the first clock after reset release
  logic after_rst_q;
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      after_rst_q <= 1'b0;
    end else begin
      after_rst_q <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  a_reset_values: assert property (!after_rst_q |-> code_q == `NPT_CODE_RST
      && more_pages_q && page_type_q && !comply_ack_q && !sent_toggle_q)
    else $error("register fields not at reset values");
  a_more_write: assert property (
      wr_hit && PSTRB[`NPT_HI_LANE] |=> more_pages_q == $past(PWDATA[`NPT_MORE_BIT]))
    else $error("more-pages flag did not take written value");
  a_rsvd_zero: assert property (!NEXT_PAGE_WORD[`NPT_RSVD_BIT] && !PRDATA[`NPT_RSVD_BIT])
    else $error("reserved bit not zero");
  a_type_readonly: assert property (!ARB_STATUS_LOAD |=> $stable(page_type_q))
    else $error("page type changed without arbitration load");
  a_ack_readonly: assert property (!ARB_STATUS_LOAD |=> $stable(comply_ack_q))
    else $error("comply ack changed without arbitration load");
  a_tog_word: assert property (LCW_SENT |=>
      NEXT_PAGE_WORD[`NPT_TOG_BIT] == !$past(LCW_SENT_TOGGLE))
    else $error("transmit word toggle not inverse of previous");
  a_code_lo_write: assert property (wr_hit && PSTRB[`NPT_LO_LANE] |=>
      NEXT_PAGE_WORD[7:0] == $past(PWDATA[7:0]))
    else $error("code low byte not written");
  a_code_hold: assert property (!wr_hit |=> $stable(code_q))
    else $error("code changed without a write");
  a_read_word: assert property (setup && !PWRITE && hit |=>
      access && PRDATA[15:0] == $past(NEXT_PAGE_WORD))
    else $error("read data differs from transmitted page");
  a_unmapped_err: assert property (setup && !hit ##1 access |-> PSLVERR && PRDATA == '0)
    else $error("unmapped access not flagged");
  // the page may only move on a bus write or an arbitration event
  a_word_stable: assert property (
      !wr_hit && !ARB_STATUS_LOAD && !LCW_SENT |=> $stable(NEXT_PAGE_WORD))
    else $error("transmitted page changed with no cause");
  a_more_hold: assert property (
      !(wr_hit && PSTRB[`NPT_HI_LANE]) |=> $stable(more_pages_q))
    else $error("more-pages flag changed without a write");
  a_code_hi_write: assert property (wr_hit && PSTRB[`NPT_HI_LANE] |=>
      NEXT_PAGE_WORD[`NPT_CODE_MSB:`NPT_HI_LANE_LSB] ==
      $past(PWDATA[`NPT_CODE_MSB:`NPT_HI_LANE_LSB]))
    else $error("code high bits not written");
  a_type_load: assert property (ARB_STATUS_LOAD |=>
      page_type_q == $past(ARB_PAGE_TYPE))
    else $error("page type did not take arbitration value");
  a_ack_load: assert property (ARB_STATUS_LOAD |=>
      comply_ack_q == $past(ARB_COMPLY))
    else $error("comply ack did not take arbitration value");
  a_tog_hold: assert property (!LCW_SENT |=>
      $stable(NEXT_PAGE_WORD[`NPT_TOG_BIT]))
    else $error("toggle bit moved without a sent word");
  // bus side: answered at once, mapped accesses clean, no read data on writes
  a_zero_wait: assert property (
      access |-> PREADY)
    else $error("access cycle not answered at once");
  a_mapped_ok: assert property (
      access && hit |-> !PSLVERR)
    else $error("mapped access flagged as error");
  a_write_rdata: assert property (
      setup && PWRITE |=> PRDATA == '0)
    else $error("read data not idle during a write");

  c_write_page: cover property (wr_hit && PSTRB == 4'hF);
  c_read_page: cover property (access && !PWRITE && hit);
  c_arb_load: cover property (ARB_STATUS_LOAD && !ARB_PAGE_TYPE);
  c_unmapped: cover property (PSLVERR);

endmodule
`default_nettype wire

// file: np_tx_regs.svh
`ifndef NP_TX_REGS_SVH
`define NP_TX_REGS_SVH

`define NPT_REG_IDX 12'h007
`define NPT_WORD_SHIFT 2
`define NPT_MORE_BIT 15
`define NPT_RSVD_BIT 14
`define NPT_TYPE_BIT 13
`define NPT_ACK_BIT 12
`define NPT_TOG_BIT 11
`define NPT_CODE_MSB 10
`define NPT_CODE_LSB 0
`define NPT_LO_LANE 0
`define NPT_HI_LANE 1
`define NPT_LO_LANE_MSB 7
`define NPT_HI_LANE_LSB 8
`define NPT_MORE_RST 1'b1
`define NPT_TYPE_RST 1'b1
`define NPT_ACK_RST 1'b0
`define NPT_TOG_RST 1'b0
`define NPT_CODE_RST 11'h008
`define NPT_RDATA_IDLE 32'h0000_0000

`endif

// file: np_tx_pkg.sv
package np_tx_pkg;
  typedef logic [15:0] page_word_t;
  typedef logic [10:0] page_code_t;
  typedef logic [31:0] bus_word_t;
endpackage

// file: np_toggle_track.sv
`timescale 1ns/10ps
`default_nettype none
`include "np_tx_regs.svh"
module np_toggle_track (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic word_sent,
  input wire logic sent_toggle,
  output logic toggle_q
);

  // the next word must carry the opposite toggle of the last one exchanged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      toggle_q <= `NPT_TOG_RST;
    end else if (word_sent) begin
      toggle_q <= ~sent_toggle;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_toggle_inverts: assert property (word_sent |=> toggle_q == !$past(sent_toggle))
    else $error("toggle bit did not take inverse of sent toggle");
  a_toggle_holds: assert property (!word_sent |=> $stable(toggle_q))
    else $error("toggle bit changed without a sent word");
  c_toggle_flip: cover property (word_sent ##1 word_sent && sent_toggle != $past(sent_toggle));

endmodule
`default_nettype wire

// file: np_arb_model.sv
`timescale 1ns/10ps
`default_nettype none
module np_arb_model
  import np_tx_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic tog,
  input wire logic [15:0] page_word,
  output logic lcw_sent,
  output logic lcw_tog,
  output page_word_t sent_word
);
  initial begin
    lcw_sent = 1'b0;
    lcw_tog = 1'b0;
    sent_word = 16'h0000;
  end
  // toggle line wanders outside a pulse, so a stale value is never trusted
  always @(posedge clk) begin
    lcw_sent <= go;
    lcw_tog <= go ? tog : ~lcw_tog;
    if (go) begin
      sent_word <= page_word;
    end
  end
endmodule
`default_nettype wire

// file: test_autoneg_next_page_transmit_reg.sv
`timescale 1ns/10ps
`default_nettype none
`include "np_tx_regs.svh"
module test_autoneg_next_page_transmit_reg
  import np_tx_pkg::*;
;
  localparam logic [11:0] RA = 12'(`NPT_REG_IDX << `NPT_WORD_SHIFT);
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  bus_word_t pwdata = 32'h0000_0000, prdata;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, more, lcw_sent, lcw_tog;
  logic st_load = 1'b0, pg_type = 1'b0, comply = 1'b0, go = 1'b0, tog = 1'b0;
  page_word_t npw, sent_word;
  int err_total = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  autoneg_next_page_transmit_reg i_autoneg_next_page_transmit_reg (.CLK_SYS(clk),
    .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ARB_STATUS_LOAD(st_load), .ARB_PAGE_TYPE(pg_type), .ARB_COMPLY(comply),
    .LCW_SENT(lcw_sent), .LCW_SENT_TOGGLE(lcw_tog), .NEXT_PAGE_WORD(npw), .MORE_PAGES(more));
  np_arb_model i_np_arb_model (.clk(clk), .go(go), .tog(tog), .page_word(npw),
    .lcw_sent(lcw_sent), .lcw_tog(lcw_tog), .sent_word(sent_word));
  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string w, input bus_word_t exp, input bus_word_t got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", w, exp, got);
    end
  endtask
  // request stands until pready is seen high at a rising edge; answer taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input bus_word_t d,
      input logic [3:0] s, output bus_word_t rd, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input bus_word_t d, input logic [3:0] s);
    bus_word_t r;
    logic e;
    apb(1'b1, a, d, s, r, e);
  endtask
  task automatic rd_chk(input string w, input bus_word_t exp);
    bus_word_t d;
    logic e;
    apb(1'b0, RA, 32'h0000_0000, 4'h0, d, e);
    @(negedge clk);
    chk({w, " read"}, exp, d);
    chk({w, " error"}, 32'h0000_0000, 32'(e));
    chk({w, " word"}, exp, 32'(npw));
    chk({w, " more"}, 32'(exp[15]), 32'(more));
  endtask
  task automatic arb(input logic t, input logic c);
    @(posedge clk);
    st_load <= 1'b1;
    pg_type <= t;
    comply <= c;
    @(posedge clk);
    st_load <= 1'b0;
  endtask
  task automatic snd(input logic t);
    @(posedge clk);
    go <= 1'b1;
    tog <= t;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic t_reset();
    rd_chk("reset", 32'h0000_A008);
  endtask
  task automatic t_write();
    wr(RA, 32'hFFFF_FFFF, 4'hF);
    rd_chk("all ones", 32'h0000_A7FF);
    wr(RA, 32'h0000_0000, 4'hF);
    rd_chk("all zeros", 32'h0000_2000);
    wr(RA, 32'h0000_8355, 4'h1);
    rd_chk("low lane", 32'h0000_2055);
    wr(RA, 32'h0000_8300, 4'h2);
    rd_chk("high lane", 32'h0000_A355);
  endtask
  task automatic t_arb();
    arb(1'b0, 1'b1);
    rd_chk("unformatted comply", 32'h0000_9355);
    arb(1'b1, 1'b0);
    rd_chk("message no comply", 32'h0000_A355);
  endtask
  task automatic t_toggle();
    wr(RA, 32'h0000_8355, 4'h3);
    snd(1'b0);
    rd_chk("toggle after 0", 32'h0000_AB55);
    chk("page sent", 32'h0000_A355, 32'(sent_word));
    snd(1'b1);
    rd_chk("toggle after 1", 32'h0000_A355);
    chk("page sent", 32'h0000_AB55, 32'(sent_word));
  endtask
  task automatic t_unmapped();
    bus_word_t d;
    logic e;
    apb(1'b0, RA + 12'h004, 32'h0000_0000, 4'h0, d, e);
    chk("unmapped error", 32'h0000_0001, 32'(e));
    chk("unmapped data", 32'h0000_0000, d);
    wr(RA + 12'h004, 32'h0000_0000, 4'hF);
    rd_chk("after unmapped", 32'h0000_A355);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_write();
    t_arb();
    t_toggle();
    t_unmapped();
    finish_test();
  end
  initial begin
    #20000;
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire
